/* hw/hbf_fifo_if.sv */
// Filler and drainer signals of one two-half FIFO.
interface hbf_fifo_if import hbf_pkg::*; ();
  logic fill_valid;
  logic fill_two;
  logic [15:0] fill_data;
  logic [PTR_W-1:0] fill_space;
  logic commit;
  logic [PTR_W-1:0] limit;
  logic drain_take;
  logic drain_two;
  logic [15:0] drain_data;
  logic [PTR_W-1:0] drain_level;
  modport user (
    output fill_valid, fill_two, fill_data, commit, limit,
    output drain_take, drain_two,
    input fill_space, drain_data, drain_level
  );
  modport store (
    input fill_valid, fill_two, fill_data, commit, limit,
    input drain_take, drain_two,
    output fill_space, drain_data, drain_level
  );
endinterface

/* hw/hbf_half_fifo.sv */
// Two-half byte FIFO: filler owns one half, drainer the other.
module hbf_half_fifo import hbf_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH,
  parameter bit AUTO_COMMIT = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // FIFO port
  hbf_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);
  localparam int HW = AW - 1;
  logic [7:0] mem [0:DEPTH-1];
  logic fhalf_ff;
  logic [PTR_W-1:0] fptr_ff, dptr_ff, dcnt_ff;
  logic dfull_ff;
  logic [PTR_W-1:0] lim, fill_n, take_n;
  logic [AW-1:0] fa0, fa1, da0, da1;
  logic fill_ok, commit_go, drain_ok;

  // Clamp the programmed length into the legal range
  assign lim = (port.limit < RX_LEN_MIN) ? RX_LEN_MIN :
               (port.limit > HALF_LEN) ? HALF_LEN : port.limit; // see RL9
  assign fill_n = port.fill_two ? TWO_BYTES : ONE_BYTE;
  assign port.fill_space = (lim > fptr_ff) ? lim - fptr_ff : '0;
  assign commit_go = (port.commit || (AUTO_COMMIT && fptr_ff == lim)) &&
                     !dfull_ff && fptr_ff != '0; // see RL7
  // A write colliding with a swap is dropped, never split
  assign fill_ok = port.fill_valid && port.fill_space >= fill_n &&
                   !commit_go;
  assign fa0 = {fhalf_ff, fptr_ff[HW-1:0]};
  assign fa1 = {fhalf_ff, fptr_ff[HW-1:0] + 1'b1};
  assign da0 = {~fhalf_ff, dptr_ff[HW-1:0]}; // see RL7
  assign da1 = {~fhalf_ff, dptr_ff[HW-1:0] + 1'b1};
  assign port.drain_level = dfull_ff ? dcnt_ff - dptr_ff : '0;
  assign port.drain_data = {mem[da1], mem[da0]};
  assign take_n = (port.drain_two && port.drain_level >= TWO_BYTES) ?
                  TWO_BYTES : ONE_BYTE;
  assign drain_ok = port.drain_take && port.drain_level != '0;

  // Byte storage, two bytes per cycle for word writes
  always_ff @(posedge core_clk) begin
    if (fill_ok) begin
      mem[fa0] <= port.fill_data[7:0]; // see RL2
      if (port.fill_two) begin
        mem[fa1] <= port.fill_data[15:8]; // see RL6
      end
    end
  end

  // Filler pointer and half ownership
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fhalf_ff <= 1'b0;
      fptr_ff <= '0;
    end else if (commit_go) begin
      fhalf_ff <= ~fhalf_ff;
      fptr_ff <= '0;
    end else if (fill_ok) begin
      fptr_ff <= fptr_ff + fill_n;
    end
  end

  // Drainer half contents
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dfull_ff <= 1'b0;
      dptr_ff <= '0;
      dcnt_ff <= '0;
    end else if (commit_go) begin
      dfull_ff <= 1'b1;
      dptr_ff <= '0;
      dcnt_ff <= fptr_ff;
    end else if (drain_ok) begin
      if (dptr_ff + take_n >= dcnt_ff) begin
        dfull_ff <= 1'b0;
        dptr_ff <= '0;
      end else begin
        dptr_ff <= dptr_ff + take_n;
      end
    end
  end

  property p_half_bound;
    @(posedge core_clk) disable iff (rst)
    fptr_ff <= HALF_LEN && dcnt_ff <= HALF_LEN;
  endproperty
  a_half_bound: assert property (p_half_bound) // see RL7
    else $error("half pointer beyond 32 bytes");

  property p_swap;
    @(posedge core_clk) disable iff (rst)
    commit_go |=> dfull_ff && fhalf_ff != $past(fhalf_ff) &&
                  dcnt_ff == $past(fptr_ff) && fptr_ff == '0;
  endproperty
  a_swap: assert property (p_swap) // see RL7
    else $error("half swap did not hand over filled half");

  property p_fill_step;
    @(posedge core_clk) disable iff (rst)
    fill_ok |=> fptr_ff == $past(fptr_ff) + $past(fill_n);
  endproperty
  a_fill_step: assert property (p_fill_step) // see RL6
    else $error("fill pointer did not advance by access size");

  property p_limit;
    @(posedge core_clk) disable iff (rst)
    fill_ok |-> fptr_ff + fill_n <= lim && lim >= RX_LEN_MIN;
  endproperty
  a_limit: assert property (p_limit) // see RL9
    else $error("fill past programmed half length");
endmodule

/* hw/hbf_host_bus_fifo_port.sv */
// Parallel host bus port giving access to the signaling FIFOs.
module hbf_host_bus_fifo_port import hbf_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Configuration straps
  input wire logic bus_style_select,
  input wire logic bus_width_select,
  // Bus control pins
  input wire logic cs_n,
  input wire logic rd_ds_n,
  input wire logic wr_rw_n,
  input wire logic ale,
  input wire logic upper_lane_enable_n,
  input wire logic lower_lane_enable_n,
  // Address and data pins
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] d_in,
  output logic [15:0] d_out,
  output logic d_oe,
  // Framer side control
  input wire logic tx_commit,
  input wire logic [PTR_W-1:0] rx_half_len,
  // Internal highway, transmit direction
  output logic [7:0] tx_hw_data,
  output logic tx_hw_valid,
  input wire logic tx_hw_ready,
  // Internal highway, receive direction
  input wire logic [7:0] rx_hw_data,
  input wire logic rx_hw_valid,
  output logic rx_hw_ready
);
  hbf_fifo_if tx_if ();
  hbf_fifo_if rx_if ();
  logic [SY_N-1:0] raw, s1_ff, s2_ff, s3_ff, pin_ff;
  hbf_state_t state_ff;
  logic mux_ff, ale_prev_ff, ale_seen_ff;
  logic [ADDR_W-1:0] alat_ff, eff_addr;
  logic [15:0] d_out_ff;
  logic d_oe_ff;
  logic [7:0] tx_data_ff, rx_hold_ff;
  logic tx_valid_ff, rx_hold_v_ff, rx_ready_ff, nxt_rx_hold_v;
  logic style, wide, lane_n, hit, rd_act, wr_act, on_low, word;
  logic start_rd, start_wr, tx_take, rx_move, rx_acc;
  hbf_lane_t lane;
  logic [7:0] rb0, rb1, wb;

  assign raw = {bus_width_select, bus_style_select, ale, wr_rw_n,
                rd_ds_n, cs_n};

  // Three-stage pin synchronisers, value taken when stages 2 and 3 agree
  genvar gi;
  generate
    for (gi = 0; gi < SY_N; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (rst) begin
          s1_ff[gi] <= 1'b1;
          s2_ff[gi] <= 1'b1;
          s3_ff[gi] <= 1'b1;
          pin_ff[gi] <= 1'b1;
        end else begin
          s1_ff[gi] <= raw[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi]) begin
            pin_ff[gi] <= s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  assign style = pin_ff[SY_STYLE];
  assign wide = pin_ff[SY_WIDTH]; // see RL1
  // Style one uses a data strobe plus read/write level
  assign rd_act = !pin_ff[SY_CS] && !pin_ff[SY_RD] &&
                  (!style || pin_ff[SY_WR]); // see RL1
  assign wr_act = !pin_ff[SY_CS] && (style ?
                  (!pin_ff[SY_RD] && !pin_ff[SY_WR]) : !pin_ff[SY_WR]);

  // Toggling ALE in style zero selects the multiplexed bus. The first
  // change after reset only arms the detector: the synchroniser's reset
  // level may differ from a statically tied pin, which is no toggle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mux_ff <= 1'b0;
      ale_seen_ff <= 1'b0;
      ale_prev_ff <= 1'b1;
      alat_ff <= '0;
    end else begin
      ale_prev_ff <= pin_ff[SY_ALE];
      if (pin_ff[SY_ALE] != ale_prev_ff) begin
        ale_seen_ff <= 1'b1;
        if (ale_seen_ff && !style) begin
          mux_ff <= 1'b1; // see RL5
        end
      end
      if (ale_prev_ff && !pin_ff[SY_ALE]) begin
        alat_ff <= d_in[ADDR_W-1:0]; // see RL5
      end
    end
  end
  assign eff_addr = (mux_ff && !style) ? alat_ff : addr; // see RL5

  // Lane decode; address and enables are static during the strobe
  always_comb begin
    lane_n = style ? lower_lane_enable_n : upper_lane_enable_n;
    case ({lane_n, eff_addr[0]})
      2'b00: lane = LN_WORD;
      2'b01: lane = LN_ODD;
      2'b10: lane = LN_EVEN;
      default: lane = LN_NONE;
    endcase
    // 8-bit mode: always one byte on the low lane
    word = wide && lane == LN_WORD; // see RL8
    on_low = !wide || (lane == LN_ODD ? style : !style); // see RL3 see RL4
    hit = eff_addr[ADDR_W-1:1] == FIFO_ADDR && (!wide || lane != LN_NONE);
  end

  assign start_rd = state_ff == ST_IDLE && rd_act && hit;
  assign start_wr = state_ff == ST_IDLE && wr_act && hit;

  // Host access sequencing
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_rd) begin
            state_ff <= ST_READ;
          end else if (start_wr) begin
            state_ff <= ST_WRITE;
          end
        end
        ST_READ: begin
          if (!rd_act) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (!wr_act) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Receive FIFO read bytes; missing bytes read as zero, never stale data
  assign rb0 = (rx_if.drain_level != '0) ? rx_if.drain_data[7:0] : 8'h00;
  assign rb1 = (rx_if.drain_level >= TWO_BYTES) ?
               rx_if.drain_data[15:8] : 8'h00;
  assign wb = on_low ? d_in[7:0] : d_in[15:8];

  // Read data driven for the whole strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      d_out_ff <= 16'h0000;
      d_oe_ff <= 1'b0;
    end else if (start_rd) begin
      d_oe_ff <= 1'b1;
      if (word) begin
        d_out_ff <= style ? {rb0, rb1} : {rb1, rb0}; // see RL10
      end else begin
        d_out_ff <= on_low ? {8'h00, rb0} : {rb0, 8'h00}; // see RL3
      end
    end else if (state_ff == ST_READ && !rd_act) begin
      d_oe_ff <= 1'b0;
    end
  end

  // Host side of both FIFOs
  assign rx_if.drain_take = start_rd;
  assign rx_if.drain_two = word; // see RL6
  assign rx_if.commit = 1'b0;
  assign rx_if.limit = rx_half_len; // see RL9
  assign tx_if.fill_valid = start_wr;
  assign tx_if.fill_two = word; // see RL8
  assign tx_if.fill_data = !word ? {8'h00, wb} :
                           (style ? {d_in[7:0], d_in[15:8]} : d_in);
  assign tx_if.commit = tx_commit;
  assign tx_if.limit = HALF_LEN;

  // Transmit highway output stage
  assign tx_take = (!tx_valid_ff || tx_hw_ready) &&
                   tx_if.drain_level != '0;
  assign tx_if.drain_take = tx_take;
  assign tx_if.drain_two = 1'b0;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 8'h00;
    end else if (tx_take) begin
      tx_valid_ff <= 1'b1;
      tx_data_ff <= tx_if.drain_data[7:0];
    end else if (tx_hw_ready) begin
      tx_valid_ff <= 1'b0;
    end
  end

  // Receive highway input holding byte; ready is registered
  assign rx_acc = rx_hw_valid && rx_ready_ff;
  assign rx_move = rx_hold_v_ff && rx_if.fill_space != '0;
  assign rx_if.fill_valid = rx_hold_v_ff;
  assign rx_if.fill_two = 1'b0;
  assign rx_if.fill_data = {8'h00, rx_hold_ff};
  assign nxt_rx_hold_v = (rx_hold_v_ff && !rx_move) || rx_acc;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_hold_v_ff <= 1'b0;
      rx_hold_ff <= 8'h00;
      rx_ready_ff <= 1'b0;
    end else begin
      rx_hold_v_ff <= nxt_rx_hold_v;
      rx_ready_ff <= !nxt_rx_hold_v;
      if (rx_acc) begin
        rx_hold_ff <= rx_hw_data;
      end
    end
  end

  hbf_half_fifo #(.DEPTH(FIFO_DEPTH), .AUTO_COMMIT(1'b0)) u_tx (
    .core_clk(core_clk),
    .rst(rst),
    .port(tx_if.store)
  );
  hbf_half_fifo #(.DEPTH(FIFO_DEPTH), .AUTO_COMMIT(1'b1)) u_rx (
    .core_clk(core_clk),
    .rst(rst),
    .port(rx_if.store)
  );

  assign d_out = d_out_ff;
  assign d_oe = d_oe_ff;
  assign tx_hw_data = tx_data_ff;
  assign tx_hw_valid = tx_valid_ff;
  assign rx_hw_ready = rx_ready_ff;

  property p_oe_only_read;
    @(posedge core_clk) disable iff (rst)
    d_oe_ff |-> state_ff == ST_READ;
  endproperty
  a_oe_only_read: assert property (p_oe_only_read) // see RL1
    else $error("data bus driven outside a read");

  property p_narrow_no_word;
    @(posedge core_clk) disable iff (rst)
    start_rd && !wide |=> d_out_ff[15:8] == 8'h00;
  endproperty
  a_narrow_no_word: assert property (p_narrow_no_word) // see RL8
    else $error("upper lane used in 8-bit mode");

  property p_word_order;
    @(posedge core_clk) disable iff (rst)
    start_rd && word && style |=> d_out_ff[15:8] == $past(rb0);
  endproperty
  a_word_order: assert property (p_word_order) // see RL10
    else $error("style one word read not first byte high");

  property p_odd_lane0;
    @(posedge core_clk) disable iff (rst)
    start_rd && wide && !style && lane == LN_ODD |=>
      d_out_ff[7:0] == 8'h00;
  endproperty
  a_odd_lane0: assert property (p_odd_lane0) // see RL3
    else $error("style zero odd byte not on upper lane");

  property p_odd_lane1;
    @(posedge core_clk) disable iff (rst)
    start_rd && wide && style && lane == LN_ODD |=>
      d_out_ff[15:8] == 8'h00;
  endproperty
  a_odd_lane1: assert property (p_odd_lane1) // see RL4
    else $error("style one odd byte not on lower lane");

  property p_mux_style;
    @(posedge core_clk) disable iff (rst)
    $rose(mux_ff) |-> !$past(style);
  endproperty
  a_mux_style: assert property (p_mux_style) // see RL5
    else $error("multiplexed bus chosen in style one");

  property p_oe_release;
    @(posedge core_clk) disable iff (rst)
    state_ff == ST_READ && !rd_act |=> !d_oe_ff ##1 state_ff == ST_IDLE;
  endproperty
  a_oe_release: assert property (p_oe_release) // see RL1
    else $error("bus not released after read strobe");
endmodule

/* hw/hbf_pkg.sv */
// Shared constants and types for the host bus FIFO port.
// Overview of operation
// RL1 - Two bus styles, 8 or 16 bit data
// RL2 - One 64-byte FIFO per direction
// RL3 - Style zero: upper enable and A0 pick lanes
// RL4 - Style one: lower enable and A0 pick lanes
// RL5 - Style pin and toggling ALE choose bus structure
// RL6 - Byte and word FIFO accesses mix freely
// RL7 - Two 32-byte halves, host sees one
// RL8 - Word FIFO access only in 16-bit mode
// RL9 - Receive half length 32 down to 2
// RL10 - Word byte order follows style lane order
package hbf_pkg;
  localparam int FIFO_DEPTH = 64;
  localparam int HALF_BYTES = FIFO_DEPTH / 2;
  localparam int PTR_W = 6;
  localparam int ADDR_W = 8;
  localparam logic [PTR_W-1:0] HALF_LEN = 6'h20;
  localparam logic [PTR_W-1:0] RX_LEN_MIN = 6'h02;
  localparam logic [PTR_W-1:0] ONE_BYTE = 6'h01;
  localparam logic [PTR_W-1:0] TWO_BYTES = 6'h02;
  // Word address of the FIFO port (A7..A1)
  localparam logic [ADDR_W-2:0] FIFO_ADDR = 7'h00;
  // Pin synchroniser slots
  localparam int SY_CS = 0;
  localparam int SY_RD = 1;
  localparam int SY_WR = 2;
  localparam int SY_ALE = 3;
  localparam int SY_STYLE = 4;
  localparam int SY_WIDTH = 5;
  localparam int SY_N = 6;
  // Lane decode of {lane enable, A0}
  typedef enum logic [3:0] {
    LN_WORD = 4'h1,
    LN_ODD = 4'h2,
    LN_EVEN = 4'h4,
    LN_NONE = 4'h8
  } hbf_lane_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_READ = 3'h2,
    ST_WRITE = 3'h4
  } hbf_state_t;
endpackage

/* sim/hbf_host_model.sv */
// Host processor model driving the parallel bus pins of the port.
module hbf_host_model import hbf_pkg::*; (
  // Clock and bus style
  input wire logic core_clk,
  input wire logic style,
  // Bus control pins
  output logic cs_n,
  output logic rd_ds_n,
  output logic wr_rw_n,
  output logic ale,
  output logic upper_lane_enable_n,
  output logic lower_lane_enable_n,
  // Address and data pins
  output logic [ADDR_W-1:0] addr,
  output logic [15:0] d_in,
  input wire logic [15:0] d_out,
  input wire logic d_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus; static ALE keeps the demultiplexed structure
  initial begin
    cs_n = 1'b1;
    rd_ds_n = 1'b1;
    wr_rw_n = 1'b1;
    ale = 1'b0;
    upper_lane_enable_n = 1'b1;
    lower_lane_enable_n = 1'b1;
    addr = '0;
    d_in = 16'h0000;
  end

  // Multiplexed address phase: address on D7:0, latched as ALE falls
  task automatic addr_latch(input bit a0);
    @(posedge core_clk);
    d_in <= {8'h00, FIFO_ADDR, a0};
    ale <= 1'b1;
    repeat (6) @(posedge core_clk);
    ale <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  // One access; all qualifiers held until the strobe is released
  task automatic access(input bit wr, input bit a0, input bit ln,
                        input logic [15:0] wd, output logic [15:0] rd,
                        output bit ok);
    int n;
    ok = 1'b0;
    rd = 16'h0000;
    @(posedge core_clk);
    cs_n <= 1'b0;
    addr <= {FIFO_ADDR, a0};
    upper_lane_enable_n <= ln;
    lower_lane_enable_n <= ln;
    // Style one: data strobe plus read/write level
    rd_ds_n <= style ? 1'b0 : wr;
    wr_rw_n <= !wr;
    // Released data lines show the inverse, not the last value
    d_in <= wr ? wd : ~d_in;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (wr && n == 7) begin
        ok = 1'b1;
        break;
      end
      if (!wr && d_oe === 1'b1) begin
        rd = d_out;
        ok = 1'b1;
        break;
      end
    end
    cs_n <= 1'b1;
    rd_ds_n <= 1'b1;
    wr_rw_n <= 1'b1;
    d_in <= ~d_in;
    // Strobe must read inactive before the next access
    repeat (8) @(posedge core_clk);
  endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the host bus FIFO port.
module tb_top import hbf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst, bus_style_select, bus_width_select;
  logic cs_n, rd_ds_n, wr_rw_n, ale, upper_lane_enable_n;
  logic lower_lane_enable_n, d_oe, tx_commit, tx_hw_valid, tx_hw_ready;
  logic rx_hw_valid, rx_hw_ready;
  logic [ADDR_W-1:0] addr;
  logic [15:0] d_in, d_out;
  logic [PTR_W-1:0] rx_half_len;
  logic [7:0] tx_hw_data, rx_hw_data;
  logic [7:0] expq[$];
  int error_cnt, cmp_count;

  hbf_host_bus_fifo_port hbf_host_bus_fifo_port_inst (.core_clk(core_clk),
    .rst(rst), .bus_style_select(bus_style_select),
    .bus_width_select(bus_width_select), .cs_n(cs_n), .rd_ds_n(rd_ds_n),
    .wr_rw_n(wr_rw_n), .ale(ale), .upper_lane_enable_n(upper_lane_enable_n),
    .lower_lane_enable_n(lower_lane_enable_n), .addr(addr), .d_in(d_in),
    .d_out(d_out), .d_oe(d_oe), .tx_commit(tx_commit),
    .rx_half_len(rx_half_len), .tx_hw_data(tx_hw_data),
    .tx_hw_valid(tx_hw_valid), .tx_hw_ready(tx_hw_ready),
    .rx_hw_data(rx_hw_data), .rx_hw_valid(rx_hw_valid),
    .rx_hw_ready(rx_hw_ready));

  hbf_host_model hbf_host_model_inst (.core_clk(core_clk),
    .style(bus_style_select), .cs_n(cs_n), .rd_ds_n(rd_ds_n),
    .wr_rw_n(wr_rw_n), .ale(ale), .upper_lane_enable_n(upper_lane_enable_n),
    .lower_lane_enable_n(lower_lane_enable_n), .addr(addr), .d_in(d_in),
    .d_out(d_out), .d_oe(d_oe));

  // 20 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up(string what);
    error_cnt++;
    $display("Error %s expected answer seen timeout", what);
    results();
  endtask

  // Byte lane placement: style zero puts even bytes low, style one high
  function automatic logic [15:0] put(bit s, bit even, logic [7:0] b);
    return (even ^ s) ? {8'hEE, b} : {b, 8'hEE};
  endfunction
  function automatic logic [15:0] lane(bit s, bit even, logic [15:0] v);
    return {8'h00, (even ^ s) ? v[7:0] : v[15:8]};
  endfunction
  function automatic logic [15:0] word(bit s, logic [7:0] f, logic [7:0] n);
    return s ? {f, n} : {n, f};
  endfunction

  task automatic bus(bit wr, bit a0, bit ln, logic [15:0] wd,
                     output logic [15:0] rd);
    bit ok;
    hbf_host_model_inst.access(wr, a0, ln, wd, rd, ok);
    if (!ok) give_up("bus answer");
  endtask

  // Reset with straps settled; outputs must sit idle meanwhile
  task automatic do_reset(bit s, bit w);
    @(posedge core_clk);
    rst <= 1'b1;
    bus_style_select <= s;
    bus_width_select <= w;
    tx_commit <= 1'b0;
    rx_hw_valid <= 1'b0;
    tx_hw_ready <= 1'b0;
    repeat (10) @(posedge core_clk);
    check("reset d_oe", 16'h0, {15'h0, d_oe});
    check("reset tx_hw_valid", 16'h0, {15'h0, tx_hw_valid});
    check("reset rx_hw_ready", 16'h0, {15'h0, rx_hw_ready});
    check("reset d_out", 16'h0000, d_out);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic rx_push(logic [7:0] b);
    int n;
    @(posedge core_clk);
    rx_hw_valid <= 1'b1;
    rx_hw_data <= b;
    for (n = 0; n < 60; n++) begin
      @(posedge core_clk);
      if (rx_hw_ready === 1'b1) break;
    end
    if (n == 60) give_up("rx_hw_ready");
    rx_hw_valid <= 1'b0;
    rx_hw_data <= ~b;
  endtask

  // Commit, then drain with the highway stalling every other cycle
  task automatic tx_take();
    int k, got;
    bit extra;
    got = 0;
    extra = 1'b0;
    @(posedge core_clk);
    tx_commit <= 1'b1;
    @(posedge core_clk);
    tx_commit <= 1'b0;
    for (k = 0; k < 400 && got < expq.size(); k++) begin
      tx_hw_ready <= k[0];
      @(posedge core_clk);
      if (tx_hw_valid === 1'b1 && tx_hw_ready === 1'b1) begin
        check("tx byte", {8'h00, expq[got]}, {8'h00, tx_hw_data});
        got++;
      end
    end
    if (got < expq.size()) give_up("tx stream");
    tx_hw_ready <= 1'b1;
    repeat (20) begin
      @(posedge core_clk);
      if (tx_hw_valid === 1'b1) extra = 1'b1;
    end
    check("tx extra byte", 16'h0, {15'h0, extra});
  endtask

  task automatic t_tx(bit s);
    logic [15:0] v;
    bus(1, 0, 1, put(s, 1, 8'h11), v);
    bus(1, 0, 0, word(s, 8'h22, 8'h33), v);
    bus(1, 1, 0, put(s, 0, 8'h44), v);
    bus(1, 1, 1, 16'h5555, v);
    expq = {8'h11, 8'h22, 8'h33, 8'h44};
    tx_take();
    $display("Test tx lanes done, style %0d", s);
  endtask

  task automatic t_rx(bit s);
    logic [15:0] v;
    int i;
    rx_half_len <= 6'h04;
    for (i = 0; i < 4; i++) rx_push(8'hA0 + i[7:0]);
    bus(0, 0, 0, 16'h0, v);
    check("rx word", word(s, 8'hA0, 8'hA1), v);
    bus(0, 1, 0, 16'h0, v);
    check("rx odd byte", 16'h00A2, lane(s, 0, v));
    bus(0, 0, 1, 16'h0, v);
    check("rx even byte", 16'h00A3, lane(s, 1, v));
    bus(0, 0, 1, 16'h0, v);
    check("rx empty", 16'h0000, lane(s, 1, v));
    // Length below the floor counts as two bytes
    rx_half_len <= 6'h01;
    rx_push(8'h5A);
    rx_push(8'hC3);
    bus(0, 0, 0, 16'h0, v);
    check("rx short half", word(s, 8'h5A, 8'hC3), v);
    $display("Test rx lanes done, style %0d", s);
  endtask

  // Full transmit half: the 33rd byte has no room
  task automatic t_tx_full();
    logic [15:0] v;
    int i;
    expq = {};
    for (i = 0; i < 16; i++) begin
      bus(1, 0, 0, word(1, 8'h80 + {i[6:0], 1'b0},
                        8'h81 + {i[6:0], 1'b0}), v);
      expq.push_back(8'h80 + {i[6:0], 1'b0});
      expq.push_back(8'h81 + {i[6:0], 1'b0});
    end
    bus(1, 0, 1, put(1, 1, 8'h7F), v);
    tx_take();
    $display("Test tx full half done");
  endtask

  // Receive half of 32 swaps only once the 32nd byte lands
  task automatic t_rx_full();
    logic [15:0] v;
    int i;
    rx_half_len <= 6'h20;
    for (i = 0; i < 31; i++) rx_push(8'h40 + i[7:0]);
    bus(0, 0, 1, 16'h0, v);
    check("rx before swap", 16'h0000, lane(1, 1, v));
    rx_push(8'h5F);
    bus(0, 0, 1, 16'h0, v);
    check("rx after swap", 16'h0040, lane(1, 1, v));
    $display("Test rx full half done");
  endtask

  // Narrow bus: one byte on D7:0, lane pin ignored
  task automatic t_8bit();
    logic [15:0] v;
    bus(1, 0, 0, 16'hBBAA, v);
    bus(1, 1, 0, 16'h77CC, v);
    expq = {8'hAA, 8'hCC};
    tx_take();
    rx_half_len <= 6'h02;
    rx_push(8'hD1);
    rx_push(8'hD2);
    bus(0, 1, 0, 16'h0, v);
    check("narrow read", 16'h00D1, v);
    bus(0, 0, 1, 16'h0, v);
    check("narrow read lane", 16'h00D2, v);
    $display("Test narrow bus done");
  endtask

  // Toggling ALE: the latched odd address wins over the address pins
  task automatic t_mux();
    logic [15:0] v;
    hbf_host_model_inst.addr_latch(1'b1);
    bus(1, 0, 0, put(0, 0, 8'h66), v);
    expq = {8'h66};
    tx_take();
    $display("Test multiplexed bus done");
  endtask

  // Main sequence
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    rst = 1'b1;
    bus_style_select = 1'b0;
    bus_width_select = 1'b1;
    tx_commit = 1'b0;
    rx_half_len = 6'h20;
    tx_hw_ready = 1'b0;
    rx_hw_data = 8'h00;
    rx_hw_valid = 1'b0;
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0], 1'b1);
      t_tx(s[0]);
      t_rx(s[0]);
    end
    do_reset(1'b0, 1'b1);
    t_mux();
    do_reset(1'b1, 1'b1);
    t_tx_full();
    t_rx_full();
    do_reset(1'b0, 1'b0);
    t_8bit();
    results();
  end
endmodule
